//--- pse_channel.sv
`timescale 1ns/100ps
module pse_channel
   import pse_pkg::*;
(
   input  wire logic               ref_clk_i,
   input  wire logic               rst_i,
   input  wire logic               clear_i,
   input  wire logic               enable_i,
   input  wire logic               grant_i,
   input  wire logic [CLASS_W-1:0] grant_class_i,
   input  wire ch_event_t          ev_i,
   output ch_state_t               state_o,
   output logic                    seeking_o,
   output logic                    on_o
);

   ch_flags_t flags_r;
   ch_flags_t set_f;
   ch_meas_t  meas_r;
   ch_fsm_t   fsm_r;
   ch_fsm_t   fsm_nxt;

   // ==========================================================
   // Flag sets; a set in the clearing cycle survives
   always_comb begin
      set_f                             = '0;
      set_f.class_complete_flag         = ev_i.class_done;
      set_f.detect_complete_flag        = ev_i.det_done;
      set_f.disconnect_fault_flag       = ev_i.disconnect;
      set_f.overcurrent_cut_flag        = ev_i.overcurrent_cut;
      set_f.startup_fault_flag          = ev_i.startup_fault;
      set_f.current_limit_flag          = ev_i.current_limit;
      set_f.power_good_flag             = ev_i.power_good & on_o;
      set_f.power_enabled_flag          = grant_i;
      set_f.per_channel_classify_enable = enable_i;
      set_f.per_channel_detect_enable   = enable_i;
      set_f.autoclass_flag              = ev_i.autoclass_done;
      set_f.power_fault_flag            = ev_i.power_fault;
      set_f.foldback_select_bit         = ev_i.foldback;
   end

   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         flags_r <= '0;
      end else begin
         flags_r <= (clear_i ? '0 : flags_r) | set_f;
      end
   end

   // ==========================================================
   // Results and measurements
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         meas_r        <= '0;
         meas_r.police <= POLICE_ALL_ONES;
      end else begin
         if (clear_i) begin
            meas_r        <= '0;
            meas_r.police <= POLICE_ALL_ONES;
         end
         if (ev_i.det_done) begin
            meas_r.det_result     <= ev_i.det_result;
            meas_r.det_resistance <= ev_i.det_resistance;
         end
         if (ev_i.class_done) begin
            meas_r.requested_class <= ev_i.requested_class;
         end
         if (ev_i.autoclass_done) begin
            meas_r.autoclass_meas <= ev_i.autoclass_meas;
         end
         if (ev_i.meas_valid) begin
            meas_r.voltage <= ev_i.voltage;
            meas_r.current <= ev_i.current;
         end
         if (grant_i) begin
            meas_r.previous_class <= meas_r.assigned_class;
            meas_r.assigned_class <= grant_class_i;
         end
      end
   end

   // ==========================================================
   // Channel sequence
   always_comb begin
      fsm_nxt = fsm_r;
      case (fsm_r)
         ST_OFF: begin
            if (enable_i) begin
               fsm_nxt = ST_SEEK;
            end
         end
         ST_SEEK: begin
            if (grant_i) begin
               fsm_nxt = ST_ON;
            end
         end
         ST_ON: begin
            if (ev_i.disconnect | ev_i.overcurrent_cut) begin
               fsm_nxt = ST_OFF;
            end
         end
         default: begin
            fsm_nxt = ST_OFF;
         end
      endcase
      if (clear_i) begin
         fsm_nxt = ST_OFF;
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         fsm_r <= ST_OFF;
      end else begin
         fsm_r <= fsm_nxt;
      end
   end

   assign state_o   = '{flags: flags_r, meas: meas_r};
   assign seeking_o = (fsm_r == ST_SEEK);
   assign on_o      = (fsm_r == ST_ON);

endmodule

//--- pse_code_src.sv
`timescale 1ns/100ps
module pse_code_src
   import pse_pkg::*;
(
   input  wire logic              ref_clk_i,
   input  wire logic              go_i,
   input  wire logic [CODE_W-1:0] code_i,
   output logic      [CODE_W-1:0] code_o,
   output logic                   strobe_o
);
   logic [2:0] cnt_r = 3'h0;
   initial begin
      code_o = '0;
      strobe_o = 1'b0;
   end
   // ==========================================================
   // Code settles two cycles ahead of the strobe; each new shutdown is a fresh frame
   always @(posedge ref_clk_i) begin
      if (go_i) begin
         code_o <= code_i;
         cnt_r  <= 3'h6;
      end else if (cnt_r != 3'h0) begin
         cnt_r <= cnt_r - 3'h1;
      end
      strobe_o <= (cnt_r >= 3'h2) && (cnt_r <= 3'h5);
      // Idle pins show the inverse so a stale code is never mistaken for live
      if (cnt_r == 3'h1) begin
         code_o <= ~code_o;
      end
   end
endmodule

//--- pse_pkg.sv
package pse_pkg;

   // ==========================================================
   // Sizes
   localparam int NUM_CH     = 4;
   localparam int CODE_W     = 3;
   localparam int ALLOC_W    = 3;
   localparam int CLASS_W    = 3;
   localparam int DET_W      = 4;
   localparam int MEAS_W     = 14;
   localparam int DETR_W     = 16;
   localparam int ACM_W      = 8;
   localparam int POLICE_W   = 8;

   // ==========================================================
   // Command locations and field layout
   localparam logic [7:0] ALLOC_ADDR    = 8'h29;
   localparam logic [7:0] ALLOC_RESET   = 8'h00;
   localparam logic [7:0] READ_UNMAPPED = 8'h00;
   localparam int ALLOC12_LSB = 0;
   localparam int ALLOC34_LSB = 4;
   localparam int ALLOC_RSVD_BIT = 2;

   // ==========================================================
   // Allocation codes and the highest class each one admits
   localparam logic [ALLOC_W-1:0] ALLOC_15W4 = 3'h0;
   localparam logic [ALLOC_W-1:0] ALLOC_4W   = 3'h1;
   localparam logic [ALLOC_W-1:0] ALLOC_7W   = 3'h2;
   localparam logic [ALLOC_W-1:0] ALLOC_30W  = 3'h3;
   localparam logic [CLASS_W-1:0] CLASS_NONE = 3'h0;
   localparam logic [CLASS_W-1:0] CLASS_1    = 3'h1;
   localparam logic [CLASS_W-1:0] CLASS_2    = 3'h2;
   localparam logic [CLASS_W-1:0] CLASS_3    = 3'h3;
   localparam logic [CLASS_W-1:0] CLASS_4    = 3'h4;
   localparam logic [POLICE_W-1:0] POLICE_ALL_ONES = 8'hFF;

   // ==========================================================
   // Timing
   localparam int CLK_MHZ  = 100;
   localparam int COOL_MS  = 1000;
   localparam int COOL_CYC = COOL_MS * 1000 * CLK_MHZ;

   // ==========================================================
   // Channel state machine
   typedef enum logic [2:0] {
      ST_OFF  = 3'b001,
      ST_SEEK = 3'b010,
      ST_ON   = 3'b100
   } ch_fsm_t;

   // ==========================================================
   // Carriers
   typedef struct packed {
      logic class_complete_flag;
      logic detect_complete_flag;
      logic disconnect_fault_flag;
      logic overcurrent_cut_flag;
      logic startup_fault_flag;
      logic current_limit_flag;
      logic power_good_flag;
      logic power_enabled_flag;
      logic per_channel_classify_enable;
      logic per_channel_detect_enable;
      logic autoclass_flag;
      logic power_fault_flag;
      logic foldback_select_bit;
   } ch_flags_t;

   typedef struct packed {
      logic [CLASS_W-1:0]  requested_class;
      logic [DET_W-1:0]    det_result;
      logic [POLICE_W-1:0] police;
      logic [MEAS_W-1:0]   voltage;
      logic [MEAS_W-1:0]   current;
      logic [CLASS_W-1:0]  assigned_class;
      logic [CLASS_W-1:0]  previous_class;
      logic [DETR_W-1:0]   det_resistance;
      logic [ACM_W-1:0]    autoclass_meas;
   } ch_meas_t;

   typedef struct packed {
      ch_flags_t flags;
      ch_meas_t  meas;
   } ch_state_t;

   typedef struct packed {
      logic               det_done;
      logic [DET_W-1:0]   det_result;
      logic [DETR_W-1:0]  det_resistance;
      logic               class_done;
      logic [CLASS_W-1:0] requested_class;
      logic               autoclass_done;
      logic [ACM_W-1:0]   autoclass_meas;
      logic               meas_valid;
      logic [MEAS_W-1:0]  voltage;
      logic [MEAS_W-1:0]  current;
      logic               disconnect;
      logic               overcurrent_cut;
      logic               startup_fault;
      logic               current_limit;
      logic               power_good;
      logic               power_fault;
      logic               foldback;
   } ch_event_t;

endpackage

//--- pse_sa_chk.sv
`timescale 1ns/100ps
module pse_sa_chk
   import pse_pkg::*;
#(
   parameter int CH = NUM_CH
)
(
   input wire logic                       ref_clk_i,
   input wire logic                       rst_i,
   input wire logic [7:0]                 cmd_addr_i,
   input wire logic                       cmd_wr_i,
   input wire logic                       cmd_rd_i,
   input wire logic [7:0]                 cmd_wdata_i,
   input wire logic [7:0]                 cmd_rdata_o,
   input wire logic [CH-1:0][CODE_W-1:0]  channel_shutdown_priority_i,
   input wire ch_event_t [CH-1:0]         ch_event_i,
   input wire ch_state_t [CH-1:0]         ch_state_o,
   input wire logic [CH-1:0]              cooling_o,
   input wire logic [CH-1:0]              shutdown_hit_o,
   input wire logic [CH-1:0][ALLOC_W-1:0] alloc_locked_o
);
   // ==========================================================
   // Command port
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (rst_i);
   a_rd_unmapped: assert property (
      cmd_rd_i && cmd_addr_i != ALLOC_ADDR |=> cmd_rdata_o == READ_UNMAPPED)
      else $error("unmapped read not zero");
   a_rd_holds: assert property (
      !cmd_rd_i |=> $stable(cmd_rdata_o))
      else $error("read data moved without a read");
   a_wr_then_rd: assert property (
      cmd_wr_i && cmd_addr_i == ALLOC_ADDR ##1 !cmd_wr_i ##1 cmd_rd_i && !cmd_wr_i && cmd_addr_i == ALLOC_ADDR
      |=> cmd_rdata_o == $past(cmd_wdata_i, 3))
      else $error("allocation byte read back wrong");
   // ==========================================================
   // Shutdown
   a_hit_single: assert property (
      shutdown_hit_o != '0 |=> shutdown_hit_o == '0)
      else $error("shutdown pulse longer than one cycle");
   for (genvar i = 0; i < CH; i++) begin : g_ch
      // A same-cycle event may set a flag again, so those cycles are left out
      a_hit_flags: assert property (
         shutdown_hit_o[i] && $past(ch_event_i[i]) == '0 |-> ch_state_o[i].flags == '0)
         else $error("flags survive shutdown");
      a_hit_police: assert property (
         shutdown_hit_o[i] |-> ch_state_o[i].meas.police == POLICE_ALL_ONES)
         else $error("policing not all ones after shutdown");
      a_hit_meas: assert property (
         shutdown_hit_o[i] && $past(ch_event_i[i]) == '0 |-> {ch_state_o[i].meas.voltage,
         ch_state_o[i].meas.current, ch_state_o[i].meas.requested_class, ch_state_o[i].meas.det_result} == '0)
         else $error("measurements survive shutdown");
      a_hit_class: assert property (
         shutdown_hit_o[i] && $past(ch_event_i[i]) == '0 |-> {ch_state_o[i].meas.assigned_class,
         ch_state_o[i].meas.previous_class, ch_state_o[i].meas.det_resistance,
         ch_state_o[i].meas.autoclass_meas} == '0)
         else $error("class results survive shutdown");
      a_cool_kept: assert property (
         shutdown_hit_o[i] && $past(cooling_o[i]) |-> cooling_o[i])
         else $error("shutdown stopped cool-down");
      a_class_cap: assert property (
         $rose(ch_state_o[i].flags.power_enabled_flag) |->
         !(alloc_locked_o[i] == ALLOC_4W && ch_state_o[i].meas.assigned_class != CLASS_1) &&
         !(alloc_locked_o[i] == ALLOC_7W && ch_state_o[i].meas.assigned_class > CLASS_2) && !alloc_locked_o[i][2])
         else $error("power granted above allocation");
      for (genvar j = 0; j < CH; j++) begin : g_pair
         a_hit_ranked: assert property (
            shutdown_hit_o[i] && $past(channel_shutdown_priority_i[j]) >= $past(channel_shutdown_priority_i[i])
            |-> shutdown_hit_o[j])
            else $error("lower priority channel kept on");
      end
   end
endmodule

bind pse_shutdown_alloc pse_sa_chk #(.CH(CH)) u_chk (
   .ref_clk_i(ref_clk_i),
   .rst_i(rst_i),
   .cmd_addr_i(cmd_addr_i),
   .cmd_wr_i(cmd_wr_i),
   .cmd_rd_i(cmd_rd_i),
   .cmd_wdata_i(cmd_wdata_i),
   .cmd_rdata_o(cmd_rdata_o),
   .channel_shutdown_priority_i(channel_shutdown_priority_i),
   .ch_event_i(ch_event_i),
   .ch_state_o(ch_state_o),
   .cooling_o(cooling_o),
   .shutdown_hit_o(shutdown_hit_o),
   .alloc_locked_o(alloc_locked_o)
);

//--- pse_shutdown_alloc.sv
`timescale 1ns/100ps
// Behaviour
// - Priority code 000 highest, 111 lowest
// - Channels sharing one code turn off together
// - Shutdown acts as reset but cool-down continues; ins_power_fault_o is kept, where a channel reset clears it
// - Shutdown clears status, fault and enable flags
// - Shutdown clears requested class and detection fields
// - Shutdown sets two-pair policing to all ones
// - Shutdown clears voltage and current measurements
// - Shutdown clears classes, resistance, autoclass results
// - No memory of earlier shutdown codes
// - Act on each code before pulse ends
// - Allocation byte at 29h, fields 6:4, 2:0
// - Allocation field caps powered classification level
// - Codes 15.4, 4, 7, 30 W; top bit reserved
// - Allocation changes after power-on may be ignored
// - One field serves both channels of a pair
// - 4 W admits class 1 only, else fault
// - 7 W admits classes 1-2, else fault
module pse_shutdown_alloc
   import pse_pkg::*;
#(
   parameter int CH       = NUM_CH,
   parameter int COOL_CNT = COOL_CYC
)
(
   input  wire logic                           ref_clk_i,
   input  wire logic                           rst_i,
   input  wire logic [7:0]                     cmd_addr_i,
   input  wire logic                           cmd_wr_i,
   input  wire logic                           cmd_rd_i,
   input  wire logic [7:0]                     cmd_wdata_i,
   output logic      [7:0]                     cmd_rdata_o,
   input  wire logic [CODE_W-1:0]              fast_shutdown_code_i,
   input  wire logic                           fast_shutdown_strobe_i,
   input  wire logic [CH-1:0][CODE_W-1:0]      channel_shutdown_priority_i,
   input  wire logic                           auto_mode_i,
   input  wire logic [CH-1:0]                  channel_power_on_cmd_i,
   input  wire logic [CH-1:0]                  detect_enable_bit_i,
   input  wire logic [CH-1:0]                  channel_reset_i,
   input  wire logic [CH-1:0]                  ins_fault_clr_i,
   input  wire ch_event_t [CH-1:0]             ch_event_i,
   output ch_state_t [CH-1:0]                  ch_state_o,
   output logic      [CH-1:0]                  ins_power_fault_o,
   output logic      [CH-1:0]                  cooling_o,
   output logic      [CH-1:0]                  shutdown_hit_o,
   output logic      [CH-1:0][ALLOC_W-1:0]     alloc_locked_o
);

   localparam int CNT_W = $clog2(COOL_CNT + 1);
   localparam logic [CNT_W-1:0] COOL_LOAD = CNT_W'(COOL_CNT - 1);
   localparam logic [CNT_W-1:0] CNT_ZERO  = '0;

   // ==========================================================
   // Declarations
   logic [7:0]              port_power_allocation_r;
   logic [ALLOC_W-1:0]      alloc_ch12_field;
   logic [ALLOC_W-1:0]      alloc_ch34_field;

   logic [CODE_W-1:0]       code_s1_r;
   logic [CODE_W-1:0]       code_s2_r;
   logic                    stb_s1_r;
   logic                    stb_s2_r;
   logic                    stb_s3_r;
   logic                    code_fire;

   logic [CH-1:0]           shut_hit;
   logic [CH-1:0]           ch_clear;
   logic [CH-1:0]           on_req;
   logic [CH-1:0]           grant;
   logic [CH-1:0]           deny;
   logic [CH-1:0]           seeking;
   logic [CH-1:0]           powered;
   logic [CH-1:0]           cool_start;
   logic [CH-1:0][CLASS_W-1:0] req_class;
   logic [CH-1:0][CNT_W-1:0]   cool_cnt_r;
   ch_state_t [CH-1:0]         state;

   // ==========================================================
   // Pair field selection and class admission
   function automatic logic [ALLOC_W-1:0] pair_field(input int idx);
      logic [ALLOC_W-1:0] fld;
      fld = (idx < 2) ? alloc_ch12_field : alloc_ch34_field;
      return fld;
   endfunction

   function automatic logic [CLASS_W-1:0] class_cap(input logic [ALLOC_W-1:0] fld);
      logic [CLASS_W-1:0] cap;
      cap = CLASS_NONE;
      if (!fld[ALLOC_RSVD_BIT]) begin
         case (fld)
            ALLOC_4W:   cap = CLASS_1;
            ALLOC_7W:   cap = CLASS_2;
            ALLOC_15W4: cap = CLASS_3;
            ALLOC_30W:  cap = CLASS_4;
            default:    cap = CLASS_NONE;
         endcase
      end
      return cap;
   endfunction

   // ==========================================================
   // Command register
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         port_power_allocation_r <= ALLOC_RESET;
      end else if (cmd_wr_i && (cmd_addr_i == ALLOC_ADDR)) begin
         // Reserved bits are kept as written so they read back
         port_power_allocation_r <= cmd_wdata_i;
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         cmd_rdata_o <= READ_UNMAPPED;
      end else if (cmd_rd_i) begin
         if (cmd_addr_i == ALLOC_ADDR) begin
            cmd_rdata_o <= port_power_allocation_r;
         end else begin
            cmd_rdata_o <= READ_UNMAPPED;
         end
      end
   end

   assign alloc_ch12_field = port_power_allocation_r[ALLOC12_LSB +: ALLOC_W];
   assign alloc_ch34_field = port_power_allocation_r[ALLOC34_LSB +: ALLOC_W];

   // ==========================================================
   // Shutdown pin synchronisers
   // The code must settle a cycle before the strobe rises, since
   // code bits and strobe cross on separate synchronisers.
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         code_s1_r <= '0;
         code_s2_r <= '0;
      end else begin
         code_s1_r <= fast_shutdown_code_i;
         code_s2_r <= code_s1_r;
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         stb_s1_r <= 1'b0;
         stb_s2_r <= 1'b0;
         stb_s3_r <= 1'b0;
      end else begin
         stb_s1_r <= fast_shutdown_strobe_i;
         stb_s2_r <= stb_s1_r;
         stb_s3_r <= stb_s2_r;
      end
   end

   // Acting on the rising edge lets the turn-off land while the
   // strobe is still high; a held strobe fires only once.
   assign code_fire = stb_s2_r & ~stb_s3_r;

   // ==========================================================
   // Priority compare, one comparator per channel
   // Priorities are read live at the firing edge, nothing is kept.
   genvar g;
   generate
      for (g = 0; g < CH; g++) begin : g_ch
         assign shut_hit[g] = code_fire &
            (channel_shutdown_priority_i[g] >= code_s2_r);

         assign ch_clear[g] = shut_hit[g] | channel_reset_i[g];

         // Semi-auto asks by command; auto asks once class is done
         assign on_req[g] = seeking[g] &
            (auto_mode_i ? ch_event_i[g].class_done : channel_power_on_cmd_i[g]);

         assign req_class[g] = (auto_mode_i && ch_event_i[g].class_done) ?
            ch_event_i[g].requested_class : state[g].meas.requested_class;

         // A turn-off in the same cycle beats a grant
         assign grant[g] = on_req[g] & ~ch_clear[g] & ~cooling_o[g] &
            (req_class[g] <= class_cap(pair_field(g))) &
            (req_class[g] != CLASS_NONE);
         assign deny[g] = on_req[g] & ~ch_clear[g] & ~cooling_o[g] &
            ~((req_class[g] <= class_cap(pair_field(g))) &
              (req_class[g] != CLASS_NONE));

         assign cool_start[g] = ch_event_i[g].overcurrent_cut |
                                ch_event_i[g].startup_fault;

         pse_channel u_channel (
            .ref_clk_i     (ref_clk_i),
            .rst_i         (rst_i),
            .clear_i       (ch_clear[g]),
            .enable_i      (detect_enable_bit_i[g] & ~ch_clear[g]),
            .grant_i       (grant[g]),
            .grant_class_i (req_class[g]),
            .ev_i          (ch_event_i[g]),
            .state_o       (state[g]),
            .seeking_o     (seeking[g]),
            .on_o          (powered[g])
         );

         // ======================================================
         // Allocation lock taken at power-on
         always_ff @(posedge ref_clk_i) begin
            if (rst_i) begin
               alloc_locked_o[g] <= ALLOC_15W4;
            end else if (grant[g]) begin
               // Later register writes do not move a powered channel
               alloc_locked_o[g] <= pair_field(g);
            end
         end

         // ======================================================
         // Insufficient-power fault
         always_ff @(posedge ref_clk_i) begin
            if (rst_i) begin
               ins_power_fault_o[g] <= 1'b0;
            end else if (deny[g]) begin
               ins_power_fault_o[g] <= 1'b1;
            end else if (ins_fault_clr_i[g] | channel_reset_i[g]) begin
               ins_power_fault_o[g] <= 1'b0;
            end
         end

         // ======================================================
         // Cool-down timer
         // Only a channel reset cancels it; a fast shutdown leaves it
         // counting so a faulted port cannot be re-powered early.
         always_ff @(posedge ref_clk_i) begin
            if (rst_i) begin
               cool_cnt_r[g] <= CNT_ZERO;
            end else if (cool_start[g]) begin
               cool_cnt_r[g] <= COOL_LOAD;
            end else if (channel_reset_i[g]) begin
               cool_cnt_r[g] <= CNT_ZERO;
            end else if (cool_cnt_r[g] != CNT_ZERO) begin
               cool_cnt_r[g] <= cool_cnt_r[g] - CNT_W'(1);
            end
         end

         assign cooling_o[g] = (cool_cnt_r[g] != CNT_ZERO);

         // ======================================================
         // Turn-off report, registered so it rises in the same cycle the channel state shows cleared
         always_ff @(posedge ref_clk_i) begin
            if (rst_i) begin
               shutdown_hit_o[g] <= 1'b0;
            end else begin
               shutdown_hit_o[g] <= shut_hit[g];
            end
         end
      end
   endgenerate

   assign ch_state_o = state;

endmodule

//--- testbench.sv
`timescale 1ns/100ps
module testbench
   import pse_pkg::*;
;
   logic                             clk = 1'b0;
   logic                             rst = 1'b1;
   logic [7:0]                       c_addr = 8'h00;
   logic                             c_wr = 1'b0;
   logic                             c_rd = 1'b0;
   logic [7:0]                       c_wd = 8'h00;
   logic [7:0]                       c_rdata;
   logic [CODE_W-1:0]                code;
   logic                             strobe;
   logic [NUM_CH-1:0][CODE_W-1:0]    prio = '0;
   logic [NUM_CH-1:0]                pon = '0;
   logic [NUM_CH-1:0]                den = '0;
   logic [NUM_CH-1:0]                crst = '0;
   ch_event_t [NUM_CH-1:0]           ev = '0;
   ch_state_t [NUM_CH-1:0]           st;
   logic [NUM_CH-1:0]                insf;
   logic [NUM_CH-1:0]                cool;
   logic [NUM_CH-1:0]                hit;
   logic [NUM_CH-1:0][ALLOC_W-1:0]   lock;
   logic                             go = 1'b0;
   logic [CODE_W-1:0]                gcode = '0;
   logic                             amode = 1'b0;
   int                               bad_count = 0;
   int                               n_tests = 0;

   always #5 clk = ~clk;

   pse_code_src src (.ref_clk_i(clk), .go_i(go), .code_i(gcode), .code_o(code), .strobe_o(strobe));

   pse_shutdown_alloc #(.CH(NUM_CH), .COOL_CNT(20)) uut (
      .ref_clk_i(clk), .rst_i(rst), .cmd_addr_i(c_addr), .cmd_wr_i(c_wr), .cmd_rd_i(c_rd),
      .cmd_wdata_i(c_wd), .cmd_rdata_o(c_rdata), .fast_shutdown_code_i(code),
      .fast_shutdown_strobe_i(strobe), .channel_shutdown_priority_i(prio), .auto_mode_i(amode),
      .channel_power_on_cmd_i(pon), .detect_enable_bit_i(den), .channel_reset_i(crst),
      .ins_fault_clr_i(4'h0), .ch_event_i(ev), .ch_state_o(st), .ins_power_fault_o(insf),
      .cooling_o(cool), .shutdown_hit_o(hit), .alloc_locked_o(lock));

   // ==========================================================
   // Tasks
   task summarize();
      $display("comparisons %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   task chk(input logic [15:0] s, input logic [15:0] e);
      n_tests++;
      if (s !== e) begin
         bad_count++;
         $display("mismatch at %0t: saw %h expected %h", $time, s, e);
      end
   endtask
   task wr_reg(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk);
      c_addr = a;
      c_wd = d;
      c_wr = 1'b1;
      @(negedge clk);
      c_wr = 1'b0;
   endtask
   task rd_reg(input logic [7:0] a, input logic [7:0] e);
      @(negedge clk);
      c_addr = a;
      c_rd = 1'b1;
      @(negedge clk);
      c_rd = 1'b0;
      chk(c_rdata, e);
   endtask
   task reset_ch(input logic [3:0] m);
      @(negedge clk);
      crst = m;
      @(negedge clk);
      crst = '0;
   endtask
   // Seek, report a class with results, then ask for power
   task pwr(input int c, input logic [2:0] cl);
      @(negedge clk);
      den[c] = 1'b1;
      @(negedge clk);
      den[c] = 1'b0;
      ev[c] = {1'b1, 4'h5, 16'h1111, 1'b1, cl, 1'b1, 8'h5A, 1'b1, 14'h1234, 14'h0234, 7'h04};
      @(negedge clk);
      ev[c] = '0;
      pon[c] = 1'b1;
      @(negedge clk);
      pon[c] = 1'b0;
      @(negedge clk);
   endtask
   task shut(input logic [2:0] k, input logic [3:0] m);
      int i;
      @(negedge clk);
      gcode = k;
      go = 1'b1;
      @(negedge clk);
      go = 1'b0;
      i = 0;
      while (hit === '0 && i < 20) begin
         @(negedge clk);
         i++;
      end
      chk(hit, m);
      repeat (4) @(negedge clk);
   endtask

   // ==========================================================
   // Tests
   initial begin
      #200000;
      bad_count++;
      summarize();
   end
   initial begin
      repeat (8) @(negedge clk);
      rst = 1'b0;
      rd_reg(ALLOC_ADDR, ALLOC_RESET);
      chk(st[1].meas.police, POLICE_ALL_ONES);
      wr_reg(ALLOC_ADDR, 8'hFF);
      rd_reg(ALLOC_ADDR, 8'hFF);
      wr_reg(8'h2C, 8'h55);
      rd_reg(8'h2C, READ_UNMAPPED);
      rd_reg(ALLOC_ADDR, 8'hFF);
      $display("test registers done");
      // Every allocation code against class 3 on both channels of one pair
      for (int k = 0; k < 8; k++) begin
         wr_reg(ALLOC_ADDR, 8'(k));
         reset_ch(4'h3);
         pwr(0, CLASS_3);
         pwr(1, CLASS_3);
         chk({st[1].flags.power_enabled_flag, st[0].flags.power_enabled_flag},
             (k == 0 || k == 3) ? 2'b11 : 2'b00);
         chk(insf[1:0], (k == 0 || k == 3) ? 2'b00 : 2'b11);
      end
      $display("test allocation codes done");
      wr_reg(ALLOC_ADDR, 8'h21);
      reset_ch(4'hF);
      pwr(0, CLASS_1);
      pwr(1, CLASS_2);
      pwr(2, CLASS_2);
      pwr(3, CLASS_3);
      chk(insf, 4'b1010);
      chk(lock[2], ALLOC_7W);
      wr_reg(ALLOC_ADDR, 8'h33);
      chk(lock[2], ALLOC_7W);
      pwr(1, CLASS_2);
      pwr(3, CLASS_3);
      chk(st[3].flags.power_enabled_flag, 1'b1);
      $display("test class caps done");
      prio = {3'h7, 3'h3, 3'h3, 3'h0};
      @(negedge clk);
      ev[2].overcurrent_cut = 1'b1;
      @(negedge clk);
      ev[2] = '0;
      shut(3'h3, 4'b1110);
      chk(cool[2], 1'b1);
      chk(st[0].flags.power_enabled_flag, 1'b1);
      chk(st[1].flags, 16'h0000);
      chk(st[1].meas.police, POLICE_ALL_ONES);
      chk(st[1].meas.voltage, 16'h0000);
      chk(st[1].meas.det_result, 16'h0000);
      chk(st[1].meas.assigned_class, CLASS_NONE);
      shut(3'h7, 4'b1000);
      shut(3'h0, 4'b1111);
      chk(st[0].flags.power_enabled_flag, 1'b0);
      amode = 1'b1;
      reset_ch(4'h1);
      den[0] = 1'b1;
      @(negedge clk);
      den[0] = 1'b0;
      ev[0].class_done = 1'b1;
      ev[0].requested_class = CLASS_2;
      @(negedge clk);
      ev[0] = '0;
      chk(st[0].flags.power_enabled_flag, 1'b1);
      $display("test shutdown done");
      summarize();
   end
endmodule
